// File: rtl/vca_classifier.sv
// VLAN classification and link aggregation code stage with Avalon-MM config
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "vca_consts.svh"

module vca_classifier (
	// Clock and reset
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_reset,
	// Avalon-MM slave
	input  wire logic [`VCA_ADDR_W-1:0] i_avs_address,
	input  wire logic                   i_avs_read,
	input  wire logic                   i_avs_write,
	input  wire logic [31:0]            i_avs_writedata,
	output logic      [31:0]            o_avs_readdata,
	output logic                        o_avs_waitrequest,
	// Parsed frame in
	input  wire vca_pkg::vca_frame_t    i_frame,
	// Internal frame header out
	output vca_pkg::vca_hdr_t           o_hdr
);
	import vca_pkg::*;

	vca_state_t st_ff;
	vca_state_t nxt_st;

	function automatic logic [3:0] fold(input logic [127:0] v);
		logic [3:0] acc;
		acc = 4'h0;
		for (int i = 0; i < 32; i++) begin
			acc = acc ^ v[i*4 +: 4];
		end
		return acc;
	endfunction

	function automatic logic [47:0] rev48(input logic [47:0] v);
		logic [47:0] r;
		r = 48'h0;
		for (int i = 0; i < 48; i++) begin
			r[i] = v[47-i];
		end
		return r;
	endfunction

	function automatic logic [2:0] tpid_kind(
		input logic [15:0]      t,
		input logic [2:0][15:0] cust
	);
		logic [2:0] k;
		k = `VCA_KIND_NONE;
		if (t == `VCA_TPID_CUST) begin
			k = `VCA_KIND_C;
		end else if (t == `VCA_TPID_SERV) begin
			k = `VCA_KIND_S;
		end else begin
			for (int j = 2; j >= 0; j--) begin
				if (t == cust[j]) begin
					k = 3'(`VCA_KIND_X0 + j);
				end
			end
		end
		return k;
	endfunction

	function automatic logic [31:0] reg_read(
		input vca_state_t        s,
		input logic [`VCA_ADDR_W-1:0] a
	);
		logic [31:0] d;
		d = 32'h0;
		case (a)
			`VCA_OFF_AGGR: d = {23'h0, s.aggregation_code_cfg};
			`VCA_OFF_CTPID0: d = {16'h0, s.custom_service_tpid_cfg[0]};
			`VCA_OFF_CTPID1: d = {16'h0, s.custom_service_tpid_cfg[1]};
			`VCA_OFF_CTPID2: d = {16'h0, s.custom_service_tpid_cfg[2]};
			`VCA_OFF_FRAMES: d = s.frames;
			`VCA_OFF_RANDOM: d = {16'h0, s.lfsr};
			default: begin
				for (int p = 0; p < `VCA_NPORTS; p++) begin
					if (a == 8'(`VCA_OFF_PORT0 + 4*p)) begin
						d = {7'h0, s.port_tag_handling_cfg[p]};
					end
				end
			end
		endcase
		return d;
	endfunction

	logic [24:0]  pcfg;
	logic [4:0]   tpid_invalid_mask;
	logic [2:0]   kind [3];
	logic [1:0]   n_valid;
	logic         stop;
	logic         sel;
	logic [1:0]   egress_pop_setting;
	logic [15:0]  tci;
	logic [3:0]   code;
	logic [8:0]   acfg;
	logic         is_ip;
	logic         req;

	always_comb begin
		nxt_st = st_ff;
		req = i_avs_read | i_avs_write;

		// Register bus: waitrequest drops one cycle after the request
		if (req && st_ff.waitreq) begin
			nxt_st.waitreq = 1'b0;
			nxt_st.rdata = i_avs_read ? reg_read(st_ff, i_avs_address)
			                          : 32'h0;
		end else begin
			nxt_st.waitreq = 1'b1;
		end
		if (i_avs_write && !st_ff.waitreq) begin
			case (i_avs_address)
				`VCA_OFF_AGGR: nxt_st.aggregation_code_cfg =
					i_avs_writedata[`VCA_AGGR_BITS-1:0];
				`VCA_OFF_CTPID0: nxt_st.custom_service_tpid_cfg[0] =
					i_avs_writedata[15:0];
				`VCA_OFF_CTPID1: nxt_st.custom_service_tpid_cfg[1] =
					i_avs_writedata[15:0];
				`VCA_OFF_CTPID2: nxt_st.custom_service_tpid_cfg[2] =
					i_avs_writedata[15:0];
				default: begin
					for (int p = 0; p < `VCA_NPORTS; p++) begin
						if (i_avs_address == 8'(`VCA_OFF_PORT0 + 4*p)) begin
							nxt_st.port_tag_handling_cfg[p] =
								i_avs_writedata[24:0];
						end
					end
				end
			endcase
		end

		// Free-running pseudo-random source
		nxt_st.lfsr = st_ff.lfsr[0] ?
			((st_ff.lfsr >> 1) ^ `VCA_LFSR_TAPS) : (st_ff.lfsr >> 1);

		// VLAN classification
		pcfg = st_ff.port_tag_handling_cfg[i_frame.port];
		tpid_invalid_mask = pcfg[`VCA_PC_MASK_LSB +: 5];
		egress_pop_setting = pcfg[`VCA_PC_POP_LSB +: 2];
		n_valid = 2'h0;
		stop = 1'b0;
		for (int i = 0; i < 3; i++) begin
			kind[i] = tpid_kind(i_frame.tpid[i],
				st_ff.custom_service_tpid_cfg);
			if (!stop && (2'(i) < i_frame.tag_cnt) &&
			    kind[i] != `VCA_KIND_NONE &&
			    !tpid_invalid_mask[kind[i] - 3'h1]) begin
				n_valid = n_valid + 2'h1;
			end else begin
				stop = 1'b1;
			end
		end
		sel = (n_valid >= 2'h2) && pcfg[`VCA_PC_INNER];
		tci = sel ? i_frame.tci[1] : i_frame.tci[0];

		nxt_st.hdr.valid = i_frame.valid;
		if (n_valid != 2'h0) begin
			// VID zero (priority tag) kept as-is
			nxt_st.hdr.hdr_classified_priority = tci[15:13];
			nxt_st.hdr.hdr_classified_drop_eligible = tci[12];
			nxt_st.hdr.hdr_classified_vlan_id = tci[11:0];
			nxt_st.hdr.hdr_tpid_extended_kind = sel ? kind[1] : kind[0];
			nxt_st.hdr.hdr_tag_is_service =
				(sel ? kind[1] : kind[0]) != `VCA_KIND_C;
		end else begin
			nxt_st.hdr.hdr_classified_priority =
				pcfg[`VCA_PC_PCP_LSB +: 3];
			nxt_st.hdr.hdr_classified_drop_eligible = pcfg[`VCA_PC_DEI];
			nxt_st.hdr.hdr_classified_vlan_id = pcfg[`VCA_PC_VID_LSB +: 12];
			nxt_st.hdr.hdr_tpid_extended_kind = `VCA_KIND_NONE;
			nxt_st.hdr.hdr_tag_is_service = 1'b0;
		end
		// Pop count is the port's pop setting, capped at the number of valid tags n_valid
		nxt_st.hdr.hdr_tags_to_pop = (egress_pop_setting > n_valid) ?
			n_valid : egress_pop_setting;
		nxt_st.hdr.hdr_frame_had_tag =
			pcfg[`VCA_PC_AWARE] && (n_valid != 2'h0);

		// Aggregation code
		acfg = st_ff.aggregation_code_cfg;
		is_ip = i_frame.ipv4 | i_frame.ipv6;
		code = 4'h0;
		if (acfg[`VCA_AGGR_DMAC]) begin
			code = code ^ fold({80'h0, i_frame.dmac});
		end
		if (acfg[`VCA_AGGR_DMAC_REV]) begin
			code = code ^ fold({80'h0, rev48(i_frame.dmac)});
		end
		if (acfg[`VCA_AGGR_SMAC]) begin
			code = code ^ fold({80'h0, i_frame.smac});
		end
		if (acfg[`VCA_AGGR_FLOW] && i_frame.ipv6) begin
			code = code ^ fold({108'h0, i_frame.flow_label});
		end
		if (acfg[`VCA_AGGR_IP] && is_ip) begin
			code = code ^ fold(i_frame.sip) ^ fold(i_frame.dip);
		end
		if (acfg[`VCA_AGGR_L4] && is_ip && i_frame.l4_valid) begin
			code = code ^ fold({96'h0, i_frame.sport,
				i_frame.dport});
		end
		if (acfg[`VCA_AGGR_INGRESS_SERVICE_INDEX]) begin
			code = code ^ fold({116'h0, i_frame.ingress_service_index});
		end
		if (acfg[`VCA_AGGR_RAND]) begin
			code = code ^ st_ff.lfsr[3:0];
		end
		if (acfg[`VCA_AGGR_STACK] && i_frame.stack_present) begin
			code = i_frame.stack_code;
		end
		nxt_st.hdr.aggr_code = code;

		if (i_frame.valid) begin
			nxt_st.frames = st_ff.frames + 32'h1;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			st_ff <= '0;
			st_ff.aggregation_code_cfg <= `VCA_AGGR_RST;
			st_ff.custom_service_tpid_cfg <= {3{`VCA_CTPID_RST}};
			st_ff.port_tag_handling_cfg <= {`VCA_NPORTS{`VCA_PORT_RST}};
			st_ff.lfsr <= `VCA_LFSR_RST;
			st_ff.waitreq <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_avs_readdata = st_ff.rdata;
	assign o_avs_waitrequest = st_ff.waitreq;
	assign o_hdr = st_ff.hdr;

endmodule

// File: shared/vca_consts.svh
// Offsets, field positions, reset values and fixed codes of the classifier
`ifndef VCA_CONSTS_SVH
`define VCA_CONSTS_SVH

`define VCA_NPORTS        8
`define VCA_PORT_W        3
`define VCA_ADDR_W        8

`define VCA_TPID_CUST     16'h8100
`define VCA_TPID_SERV     16'h88A8

`define VCA_OFF_AGGR      8'h00
`define VCA_OFF_CTPID0    8'h04
`define VCA_OFF_CTPID1    8'h08
`define VCA_OFF_CTPID2    8'h0C
`define VCA_OFF_FRAMES    8'h10
`define VCA_OFF_RANDOM    8'h14
`define VCA_OFF_PORT0     8'h40

`define VCA_AGGR_DMAC     0
`define VCA_AGGR_DMAC_REV 1
`define VCA_AGGR_SMAC     2
`define VCA_AGGR_FLOW     3
`define VCA_AGGR_IP       4
`define VCA_AGGR_L4       5
`define VCA_AGGR_INGRESS_SERVICE_INDEX     6
`define VCA_AGGR_RAND     7
`define VCA_AGGR_STACK    8
`define VCA_AGGR_BITS     9

`define VCA_PC_VID_LSB    0
`define VCA_PC_PCP_LSB    12
`define VCA_PC_DEI        15
`define VCA_PC_INNER      16
`define VCA_PC_AWARE      17
`define VCA_PC_POP_LSB    18
`define VCA_PC_MASK_LSB   20

`define VCA_AGGR_RST      9'h000
`define VCA_CTPID_RST     16'h88A8
`define VCA_PORT_RST      25'h0020001
`define VCA_LFSR_RST      16'hACE1
`define VCA_LFSR_TAPS     16'hB400

`define VCA_KIND_NONE     3'h0
`define VCA_KIND_C        3'h1
`define VCA_KIND_S        3'h2
`define VCA_KIND_X0       3'h3

`endif

// File: shared/vca_pkg.sv
// Types shared by the classifier and its bench
package vca_pkg;

	typedef logic [15:0] vca_tpid_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  port;
		logic [1:0]  tag_cnt;
		logic [2:0][15:0] tpid;
		logic [2:0][15:0] tci;
		logic [47:0] dmac;
		logic [47:0] smac;
		logic        ipv4;
		logic        ipv6;
		logic [127:0] sip;
		logic [127:0] dip;
		logic [19:0] flow_label;
		logic        l4_valid;
		logic [15:0] sport;
		logic [15:0] dport;
		logic [11:0] ingress_service_index;
		logic        stack_present;
		logic [3:0]  stack_code;
	} vca_frame_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  hdr_classified_priority;
		logic        hdr_classified_drop_eligible;
		logic [11:0] hdr_classified_vlan_id;
		logic        hdr_tag_is_service;
		logic [2:0]  hdr_tpid_extended_kind;
		logic [1:0]  hdr_tags_to_pop;
		logic        hdr_frame_had_tag;
		logic [3:0]  aggr_code;
	} vca_hdr_t;

	typedef struct packed {
		logic [24:0] cfg;
	} vca_port_cfg_t;

	typedef struct packed {
		logic [8:0]  aggregation_code_cfg;
		logic [2:0][15:0] custom_service_tpid_cfg;
		logic [7:0][24:0] port_tag_handling_cfg;
		logic [15:0] lfsr;
		logic [31:0] frames;
		vca_hdr_t    hdr;
		logic        waitreq;
		logic [31:0] rdata;
	} vca_state_t;

endpackage

// File: verif/vca_classifier_props.sv
// Port checker for the VLAN classifier
`timescale 1ns/1ps
module vca_classifier_props (
	// Clock and reset
	input wire logic              i_sys_clk,
	input wire logic              i_reset,
	// Register bus
	input wire logic [7:0]        i_avs_address,
	input wire logic              i_avs_read,
	input wire logic              i_avs_write,
	input wire logic [31:0]       i_avs_writedata,
	input wire logic [31:0]       o_avs_readdata,
	input wire logic              o_avs_waitrequest,
	// Frame path
	input wire vca_pkg::vca_frame_t i_frame,
	input wire vca_pkg::vca_hdr_t   o_hdr
);
	import vca_pkg::*;
	logic [8:0] ag_ff;
	always_ff @(posedge i_sys_clk or posedge i_reset)
		if (i_reset)
			ag_ff <= 9'h000;
		else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h00)
			ag_ff <= i_avs_writedata[8:0];
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	sequence s_frame; i_frame.valid; endsequence
	sequence s_hdr; o_hdr.valid; endsequence
	a_hdr_follows: assert property (s_frame |=> s_hdr)
		else $error("header missing after frame");
	a_hdr_alone: assert property (!i_frame.valid |=> !o_hdr.valid)
		else $error("header without frame");
	a_pop_limit: assert property (s_hdr |->
		o_hdr.hdr_tags_to_pop <= $past(i_frame.tag_cnt))
		else $error("pop count above tags present");
	a_default_kind: assert property (s_frame ##0 i_frame.tag_cnt == 2'h0 |=>
		o_hdr.hdr_tpid_extended_kind == 3'h0 && !o_hdr.hdr_frame_had_tag)
		else $error("untagged frame got tag kind");
	a_ctag_kind: assert property (s_hdr ##0 o_hdr.hdr_tpid_extended_kind == 3'h1 |->
		$past(i_frame.tpid[0]) == 16'h8100 || $past(i_frame.tpid[1]) == 16'h8100)
		else $error("customer kind without its tpid");
	a_stag_kind: assert property (s_hdr ##0 o_hdr.hdr_tpid_extended_kind == 3'h2 |->
		$past(i_frame.tpid[0]) == 16'h88A8 || $past(i_frame.tpid[1]) == 16'h88A8)
		else $error("service kind without its tpid");
	a_kind_service: assert property (s_hdr |->
		o_hdr.hdr_tag_is_service ==
		(o_hdr.hdr_tpid_extended_kind != 3'h1 &&
		o_hdr.hdr_tpid_extended_kind != 3'h0))
		else $error("service flag disagrees with kind");
	a_had_tag_kind: assert property (s_hdr ##0 o_hdr.hdr_frame_had_tag |->
		o_hdr.hdr_tpid_extended_kind != 3'h0)
		else $error("had-tag flag without a tag");
	a_stack_code: assert property (s_frame ##0 (ag_ff[8] && i_frame.stack_present) |=>
		o_hdr.aggr_code == $past(i_frame.stack_code))
		else $error("stack code not used");
	a_code_zero: assert property (s_frame ##0 ag_ff == 9'h000 |=> o_hdr.aggr_code == 4'h0)
		else $error("code nonzero with no contribution");
endmodule

// File: verif/vca_fwd_sink.sv
// Downstream forwarding stage model taking classified headers
`timescale 1ns/1ps
module vca_fwd_sink (
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset,
	// Header in, header count and mask choice out
	input  wire vca_pkg::vca_hdr_t i_hdr,
	output int                     o_count,
	output logic [15:0]            o_mask_sel
);
	import vca_pkg::*;
	always_ff @(posedge i_sys_clk or posedge i_reset)
		if (i_reset) begin
			o_count <= 0;
			o_mask_sel <= 16'h0000;
		end else if (i_hdr.valid) begin
			o_count <= o_count + 1;
			o_mask_sel <= 16'h0001 << i_hdr.aggr_code;
		end
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the VLAN classifier
`timescale 1ns/1ps
module tb_top;
	import vca_pkg::*;
	logic        clk = 1'b0;
	logic        rst, rd, wr, wt;
	logic [7:0]  adr;
	logic [31:0] wd, rdat, q;
	vca_frame_t  fr;
	vca_hdr_t    hdr;
	int          cnt, num_errors = 0, n_tests = 0, cyc = 0, sent = 0;
	logic [24:0] pc [8];
	logic [15:0] cu [3];
	logic [8:0]  ag;
	logic [15:0] lf;
	vca_hdr_t    eq [$];
	always #5 clk = ~clk;
	vca_classifier DUT (.i_sys_clk(clk), .i_reset(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_frame(fr),
		.o_hdr(hdr));
	vca_fwd_sink u_sink (.i_sys_clk(clk), .i_reset(rst), .i_hdr(hdr),
		.o_count(cnt), .o_mask_sel());
	task report_and_stop;
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: word %h exp %h", $time, g, e);
		end
	endtask
	task chk_h(input vca_hdr_t g, input vca_hdr_t e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: hdr %h exp %h", $time, g, e);
		end
	endtask
	function automatic logic [3:0] fold(input logic [127:0] v);
		fold = 4'h0;
		for (int i = 0; i < 32; i++)
			fold ^= v[i*4+:4];
	endfunction
	function automatic logic [2:0] kind(input logic [15:0] t);
		if (t == 16'h8100) return 3'h1;
		if (t == 16'h88A8) return 3'h2;
		for (int i = 0; i < 3; i++)
			if (t == cu[i]) return 3'h3 + 3'(i);
		return 3'h0;
	endfunction
	function automatic vca_hdr_t model(input vca_frame_t f);
		vca_hdr_t    h;
		logic [24:0] c;
		logic [2:0]  k [3];
		logic [3:0]  a;
		int          n, s;
		h = '0;
		c = pc[f.port];
		n = 0;
		while (n < f.tag_cnt) begin
			k[n] = kind(f.tpid[n]);
			if (k[n] == 3'h0 || c[19 + k[n]]) break;
			n++;
		end
		s = (n >= 2 && c[16]) ? 1 : 0;
		h.valid = 1'b1;
		{h.hdr_classified_priority, h.hdr_classified_drop_eligible,
			h.hdr_classified_vlan_id} = n > 0 ? f.tci[s] :
			{c[14:12], c[15], c[11:0]};
		h.hdr_tpid_extended_kind = n > 0 ? k[s] : 3'h0;
		h.hdr_tag_is_service = n > 0 && h.hdr_tpid_extended_kind != 3'h1;
		h.hdr_tags_to_pop = c[19:18] > n ? 2'(n) : c[19:18];
		h.hdr_frame_had_tag = c[17] && n > 0;
		a = 4'h0;
		if (ag[0]) a ^= fold(f.dmac);
		if (ag[1]) a ^= fold({<<{f.dmac}});
		if (ag[2]) a ^= fold(f.smac);
		if (ag[3] && f.ipv6) a ^= fold(f.flow_label);
		if (ag[4] && (f.ipv4 || f.ipv6)) a ^= fold(f.sip ^ f.dip);
		if (ag[5] && (f.ipv4 || f.ipv6) && f.l4_valid)
			a ^= fold({f.sport, f.dport});
		if (ag[6]) a ^= fold(f.ingress_service_index);
		if (ag[7]) a ^= lf[3:0];
		h.aggr_code = ag[8] && f.stack_present ? f.stack_code : a;
		return h;
	endfunction
	function automatic vca_frame_t rnd();
		vca_frame_t  f;
		logic [15:0] t [6] = '{16'h8100, 16'h88A8, cu[0], cu[1], cu[2], 16'h1234};
		for (int i = 0; i < $bits(f); i++)
			f[i] = 1'($urandom);
		f.valid = 1'b1;
		for (int i = 0; i < 3; i++)
			f.tpid[i] = t[$urandom % 6];
		f.ipv6 &= !f.ipv4;
		if (f.ipv4) begin
			f.sip[127:32] = '0;
			f.dip[127:32] = '0;
		end
		return f;
	endfunction
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			num_errors++;
			report_and_stop;
		end
		if (hdr.valid === 1'b1)
			chk_h(hdr, eq.pop_front());
		if (fr.valid === 1'b1) begin
			eq.push_back(model(fr));
			sent++;
		end
		lf <= rst ? 16'hACE1 : {1'b0, lf[15:1]} ^ (lf[0] ? 16'hB400 : 16'h0000);
	end
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task put(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		if (a == 8'h00) ag = d[8:0];
		else if (a >= 8'h40) pc[int'(a - 8'h40) / 4] = d[24:0];
		else if (a <= 8'h0C) cu[int'(a) / 4 - 1] = d[15:0];
	endtask
	task get(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	initial begin
		void'($urandom(81));
		rst = 1'b1;
		rd = 1'b0;
		wr = 1'b0;
		adr = 8'h00;
		wd = 32'h0;
		fr = '0;
		ag = 9'h000;
		cu = '{3{16'h88A8}};
		pc = '{8{25'h0020001}};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		get(8'h00, 32'h0);
		get(8'h04, 32'h88A8);
		get(8'h5C, 32'h0020001);
		get(8'h20, 32'h0);
		send(20);
		put(8'h10, 32'hFFFF);
		get(8'h10, sent);
		for (int i = 0; i < 3; i++)
			put(8'h04 + 8'(4 * i), 32'h9100 + i);
		get(8'h08, 32'h9101);
		for (int m = 0; m < 12; m++) begin
			for (int p = 0; p < 8; p++)
				put(8'h40 + 8'(4 * p), $urandom);
			put(8'h00, m < 9 ? 32'h1 << m : $urandom);
			send(30);
		end
		get(8'h44, {7'h0, pc[1]});
		repeat (3) @(posedge clk);
		chk(cnt, sent);
		report_and_stop;
	end
	task send(input int n);
		repeat (n) begin
			@(posedge clk);
			fr <= rnd();
		end
		@(posedge clk);
		fr <= '0;
	endtask
endmodule

bind vca_classifier vca_classifier_props u_props (.i_sys_clk(i_sys_clk),
	.i_reset(i_reset), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_frame(i_frame),
	.o_hdr(o_hdr));
